// ---- shared/esm_defs.svh ----
// Constants for the eight-line asynchronous serial multiplexer
`ifndef ESM_DEFS_SVH
`define ESM_DEFS_SVH
// ==========================================================
// Timing
`define ESM_CLK_HZ 125000000
`define ESM_CLK_MHZ 125
`define ESM_SCAN_NS 3250
`define ESM_SCAN_CYC ((`ESM_SCAN_NS * `ESM_CLK_MHZ + 999) / 1000)
`define ESM_OS_RATE 16
`define ESM_OS_MID 4'd7
`define ESM_OS_LAST 4'd15
`define ESM_SLOTS 24
`define ESM_LAST_SLOT 5'd23
// ==========================================================
// Register byte offsets and device code field
`define ESM_OFF_OUT_A 8'h00
`define ESM_OFF_OUT_B 8'h04
`define ESM_OFF_OUT_C 8'h08
`define ESM_OFF_IN_A 8'h0c
`define ESM_OFF_IN_B 8'h10
`define ESM_OFF_IN_C 8'h14
`define ESM_OFF_CTRL 8'h18
`define ESM_ADR_DEV 13:8
`define ESM_DEV_STD_PRI 6'o34
`define ESM_DEV_STD_SEC 6'o44
`define ESM_DEV_ALT_PRI 6'o36
`define ESM_DEV_ALT_SEC 6'o46
// ==========================================================
// Data word fields
`define ESM_B_TOP 15
`define ESM_B_NEXT 14
`define ESM_F_LINE 2:0
`define ESM_F_SEC 15:14
`define ESM_F_KIND 9:8
`define ESM_F_CHAR 7:0
`define ESM_F_RXST 14:12
`define ESM_F_MDST 14:11
`define ESM_KIND_DATA 2'd0
`define ESM_KIND_BRK 2'd1
`define ESM_KIND_MDM 2'd2
`define ESM_C_START 0
`define ESM_C_CLEAR 1
`define ESM_C_IOPLS 2
`define ESM_C_MASK 3
// ==========================================================
// Strap vector positions
`define ESM_SP_BUS_IO_RESET 0
`define ESM_SP_PRIO 1
`define ESM_SP_BDIS 2
`define ESM_SP_J1 3
`define ESM_SP_J2 4
`define ESM_SP_J3 5
`define ESM_SP_DEF 9:6
`define ESM_SP_RET 13:10
`define ESM_SP_SPLIT 14
`define ESM_SP_W 22
// ==========================================================
// Line defaults
`define ESM_DEF_WLEN 2'd2
`define ESM_DEF_PAR_EN 1'b1
`define ESM_DEF_PAR_ODD 1'b0
`define ESM_DEF_STOP2 1'b1
`define ESM_WLEN_BASE 4'd5
`endif

// ---- shared/esm_pkg.sv ----
// Types for the eight-line asynchronous serial multiplexer
package esm_pkg;
  typedef enum logic [1:0] {SEC_RX, SEC_TX, SEC_MDM} esm_sec_t;
  typedef enum logic {ST_INIT, ST_RUN} esm_state_t;
  typedef struct packed {
    logic [1:0] wlen; logic par_en; logic par_odd; logic stop2; logic [3:0] baud;
    logic rx_en; logic tx_en; logic md_en; logic loop;
  } esm_cfg_t;
  typedef struct packed {
    esm_state_t st; logic [2:0] init_cnt; logic busy; logic online; logic msk;
    logic [21:0] pin_m; logic [21:0] pin_s; logic iord;
    esm_cfg_t [7:0] cfg;
    logic [7:0][16:0] tdiv; logic [7:0][16:0] rdiv;
    logic [7:0] rx_m; logic [7:0] rx_s;
    logic [7:0][3:0] md_m; logic [7:0][3:0] md_s; logic [7:0][3:0] md_p;
    logic [7:0] rx_act; logic [7:0][3:0] rx_cnt; logic [7:0][3:0] rx_bit;
    logic [7:0][7:0] rx_sh; logic [7:0] rx_par; logic [7:0][7:0] rx_buf;
    logic [7:0] rx_full; logic [7:0] rx_ferr; logic [7:0] rx_perr; logic [7:0] rx_ovr;
    logic [7:0][7:0] tx_hold; logic [7:0] tx_full; logic [7:0][11:0] tx_sh;
    logic [7:0][3:0] tx_left; logic [7:0][3:0] tx_cnt; logic [7:0] tx_brk; logic [7:0] tx_o;
    logic [7:0] md_req; logic [7:0] dtr; logic [7:0] rts; logic [7:0] rts_off;
    logic [2:0] cur_line; esm_sec_t cur_sec; logic cur_svc;
    logic [4:0] ptr; logic [8:0] scan_cnt; logic found;
    logic ack; logic [15:0] dat;
  } esm_st_t;
endpackage

// ---- hdl/esm_top.sv ----
// Eight-line asynchronous serial multiplexer with Wishbone register access
// ==========================================================
// Functional notes
// RULE_01: Busy initialisation sets RTS off, 7 bits, even parity, 2 stops, default rate.
// RULE_02: Board is off line after init; a clear command puts it on line.
// RULE_03: A complete character on an enabled receiver requests service and done.
// RULE_04: Service read returns bit 15 one for transmitter, zero otherwise.
// RULE_05: Status read bit 15 is zero for receiver, one for modem change.
// RULE_06: Receiver status in bits 12-14, modem status in bits 11-14.
// RULE_07: Receive data read with clear returns the character and clears its request.
// RULE_08: A line may receive at a fixed strapped return rate of 9600/300/150/110.
// RULE_09: Enabled transmitter requests only with empty buffer and clear-to-send active.
// RULE_10: Transmit data write loads the transmitter and clears its done condition.
// RULE_11: Break holds output spacing and stops transmission until the next character.
// RULE_12: Enabled modem requests on any input change, or active input going on line.
// RULE_13: No-transfer clear cancels the current line's modem request.
// RULE_14: Modem control sets DTR from bit 15, RTS from bit 14; RTS off waits for idle.
// RULE_15: Loopback feeds transmitter to receiver and forces clear-to-send active.
// RULE_16: Commands act on the current line and section set by select or service read.
// RULE_17: Host ignores status for transmitter or non-service selection.
// RULE_18: Default rate comes from the 4-bit switch code decode table.
// RULE_19: Baud strobe disable keeps the default rate but allows other changes.
// RULE_20: Responds on strap-selected device code 34, 44, 36 or 46 octal.
// RULE_21: Sync priority input defers the multiplexer's own service.
// RULE_22: Scanner dwells 3.25 us per section, receivers first, reports highest.
// RULE_23: Start sets busy, on line, clears done, initialises, then off line.
// RULE_24: New character into an unread buffer flags overrun.
// RULE_25: Off line, each I/O pulse is one timing step; on line the clock times.
// RULE_26: Line characteristics and section enables are loaded by the C output.
// RULE_27: Done stays set while a request is pending; interrupt only when unmasked.
//
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`include "esm_defs.svh"
module esm_top import esm_pkg::*; (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Host bus control
  input wire logic bus_io_reset_i,
  input wire logic sync_prio_i,
  output logic irq_o,
  // Straps
  input wire logic baud_strobe_dis_i,
  input wire logic devcode_j1_i,
  input wire logic devcode_j2_i,
  input wire logic devcode_j3_i,
  input wire logic [3:0] def_rate_i,
  input wire logic [3:0] ret_rate_i,
  input wire logic [7:0] split_rate_i,
  // Serial lines
  input wire logic [7:0] rxd_i,
  input wire logic [7:0] cts_i,
  input wire logic [7:0] dsr_i,
  input wire logic [7:0] dcd_i,
  input wire logic [7:0] ri_i,
  output logic [7:0] txd_o,
  output logic [7:0] rts_o,
  output logic [7:0] dtr_o
);
  // ==========================================================
  // Rate decode
  function automatic logic [16:0] div_of(input int baud);
    if (baud == 0) return 17'd0;
    return 17'(`ESM_CLK_HZ / (`ESM_OS_RATE * baud));
  endfunction
  function automatic int baud_of(input logic [3:0] code);
    case (code) // [RULE_18]
      4'h0: return 0;
      4'h3: return 75;
      4'h6: return 600;
      4'h7, 4'hc: return 2400;
      4'h8: return 9600;
      4'h9: return 4800;
      4'hb: return 1200;
      4'hd: return 300;
      4'he: return 150;
      4'hf: return 110;
      default: return 19200;
    endcase
  endfunction
  function automatic int ret_of(input logic [3:0] sw);
    if (sw[0]) return 9600; // [RULE_08]
    if (sw[1]) return 300;
    if (sw[2]) return 150;
    if (sw[3]) return 110;
    return 0;
  endfunction
  // Start bit, data LSB first, optional parity, stops; length in the top nibble
  function automatic logic [15:0] frame_of(input logic [7:0] ch, input esm_cfg_t c);
    logic [11:0] f;
    logic [3:0] nb;
    logic [7:0] m;
    f = '1;
    nb = `ESM_WLEN_BASE + {2'd0, c.wlen};
    m = 8'(8'hff >> (4'd8 - nb));
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(nb)) f[1 + i] = ch[i];
    end
    if (c.par_en) f[1 + nb] = (^(ch & m)) ^ c.par_odd;
    return {4'd2 + nb + {3'd0, c.par_en} + {3'd0, c.stop2}, f};
  endfunction
  // ==========================================================
  // State
  esm_st_t s_r, s_nxt;
  logic [23:0] req;
  logic [21:0] pins;
  logic [5:0] dev;
  logic [15:0] d, rdat;
  logic [7:0] off;
  logic [4:0] k;
  logic [3:0] nb;
  logic [2:0] cl;
  logic [15:0] fr;
  logic sel, hit, wr, rd, prio, go_init, tt, tr, cts_e, rxin, bad;
  logic rd_a, rd_c;
  int tb, rb;
  assign pins = {split_rate_i, ret_rate_i, def_rate_i, devcode_j3_i, devcode_j2_i,
                 devcode_j1_i, baud_strobe_dis_i, sync_prio_i, bus_io_reset_i};
  always_comb begin
    s_nxt = s_r;
    req = '0;
    rdat = '0;
    fr = '0;
    nb = '0;
    k = '0;
    tt = 1'b0;
    tr = 1'b0;
    cts_e = 1'b0;
    rxin = 1'b0;
    bad = 1'b0;
    tb = 0;
    rb = 0;
    // Pins pass two flops before use
    s_nxt.pin_m = pins;
    s_nxt.pin_s = s_r.pin_m;
    s_nxt.rx_m = rxd_i;
    s_nxt.rx_s = s_r.rx_m;
    for (int l = 0; l < 8; l++) begin
      s_nxt.md_m[l] = {ri_i[l], dcd_i[l], dsr_i[l], cts_i[l]};
    end
    s_nxt.md_s = s_r.md_m;
    s_nxt.iord = s_r.pin_s[`ESM_SP_BUS_IO_RESET];
    prio = s_r.pin_s[`ESM_SP_PRIO];
    // Device code straps: a set bit means the jumper is fitted
    if (!s_r.pin_s[`ESM_SP_J2] && s_r.pin_s[`ESM_SP_J3]) begin
      dev = s_r.pin_s[`ESM_SP_J1] ? `ESM_DEV_ALT_PRI : `ESM_DEV_ALT_SEC; // [RULE_20]
    end else begin
      dev = s_r.pin_s[`ESM_SP_J1] ? `ESM_DEV_STD_PRI : `ESM_DEV_STD_SEC; // [RULE_20]
    end
    // ==========================================================
    // Wishbone decode; side effects happen once, in the cycle ack is raised
    sel = wb_cyc_i && wb_stb_i && !s_r.ack;
    s_nxt.ack = sel;
    hit = sel && (wb_adr_i[`ESM_ADR_DEV] == dev);
    wr = hit && wb_we_i && (|wb_sel_i[1:0]);
    rd = hit && !wb_we_i;
    off = wb_adr_i[7:0];
    d = wb_dat_i[15:0];
    cl = s_r.cur_line;
    rd_a = rd && off == `ESM_OFF_IN_A;
    rd_c = rd && off == `ESM_OFF_IN_C;
    k = s_r.ptr - 5'd8;
    if (wr) begin
      case (off)
        `ESM_OFF_OUT_A: begin
          s_nxt.cur_line = d[`ESM_F_LINE]; // [RULE_16]
          s_nxt.cur_sec = esm_sec_t'(d[`ESM_F_SEC]);
          s_nxt.cur_svc = 1'b0;
        end
        `ESM_OFF_OUT_B: begin
          case (d[`ESM_F_KIND])
            `ESM_KIND_DATA: begin
              s_nxt.tx_hold[cl] = d[`ESM_F_CHAR]; // [RULE_10]
              s_nxt.tx_full[cl] = 1'b1;
              s_nxt.tx_brk[cl] = 1'b0; // [RULE_11]
            end
            `ESM_KIND_BRK: s_nxt.tx_brk[cl] = 1'b1; // [RULE_11]
            `ESM_KIND_MDM: begin
              s_nxt.dtr[cl] = d[`ESM_B_TOP]; // [RULE_14]
              s_nxt.rts[cl] = s_r.rts[cl] | d[`ESM_B_NEXT];
              s_nxt.rts_off[cl] = !d[`ESM_B_NEXT];
            end
            default: ;
          endcase
        end
        `ESM_OFF_OUT_C: begin
          if (d[`ESM_B_TOP]) begin
            s_nxt.cfg[cl].wlen = d[1:0]; // [RULE_26]
            s_nxt.cfg[cl].par_en = d[2];
            s_nxt.cfg[cl].par_odd = d[3];
            s_nxt.cfg[cl].stop2 = d[4];
            if (!s_r.pin_s[`ESM_SP_BDIS]) s_nxt.cfg[cl].baud = d[8:5]; // [RULE_19]
          end else begin
            s_nxt.cfg[cl].rx_en = d[0]; // [RULE_26]
            s_nxt.cfg[cl].tx_en = d[1];
            s_nxt.cfg[cl].md_en = d[2];
            s_nxt.cfg[cl].loop = d[3];
          end
        end
        `ESM_OFF_CTRL: begin
          s_nxt.msk = d[`ESM_C_MASK];
          if (d[`ESM_C_CLEAR]) begin
            if (!s_r.online && !s_r.busy) begin
              s_nxt.online = 1'b1; // [RULE_02]
              for (int l = 0; l < 8; l++) begin
                if (s_r.cfg[l].md_en && |s_r.md_s[l]) s_nxt.md_req[l] = 1'b1; // [RULE_12]
              end
            end else begin
              s_nxt.md_req[cl] = 1'b0; // [RULE_13]
            end
          end
        end
        default: ;
      endcase
    end
    if (rd) begin
      case (off)
        `ESM_OFF_IN_A: begin
          if (s_r.found) begin
            s_nxt.cur_svc = 1'b1; // [RULE_16]
            s_nxt.cur_line = s_r.ptr < 5'd8 ? s_r.ptr[2:0] : k[3:1];
            s_nxt.cur_sec = s_r.ptr < 5'd8 ? SEC_RX : (k[0] ? SEC_MDM : SEC_TX);
          end
          rdat[`ESM_F_LINE] = s_nxt.cur_line;
          rdat[`ESM_B_TOP] = s_nxt.cur_sec == SEC_TX; // [RULE_04]
        end
        `ESM_OFF_IN_B: begin
          rdat[`ESM_F_CHAR] = s_r.rx_buf[cl]; // [RULE_07]
          s_nxt.rx_full[cl] = 1'b0;
          s_nxt.rx_ferr[cl] = 1'b0;
          s_nxt.rx_perr[cl] = 1'b0;
          s_nxt.rx_ovr[cl] = 1'b0;
        end
        `ESM_OFF_IN_C: begin
          if (s_r.cur_sec == SEC_MDM) begin
            rdat[`ESM_B_TOP] = 1'b1; // [RULE_05]
            rdat[`ESM_F_MDST] = s_r.md_s[cl]; // [RULE_06]
          end else begin
            rdat[`ESM_F_RXST] = {s_r.rx_ferr[cl], s_r.rx_perr[cl], s_r.rx_ovr[cl]}; // [RULE_06]
          end
        end
        `ESM_OFF_CTRL: rdat[3:0] = {s_r.busy, s_r.found && !prio, s_r.online, s_r.msk};
        default: ;
      endcase
    end
    s_nxt.dat = rdat;
    // ==========================================================
    // Per-line engines; hardware sets come after bus clears, so sets win
    for (int l = 0; l < 8; l++) begin
      tb = baud_of(s_r.cfg[l].baud);
      rb = s_r.pin_s[`ESM_SP_SPLIT + l] ? ret_of(s_r.pin_s[`ESM_SP_RET]) : tb; // [RULE_08]
      if (s_r.online) begin
        tt = div_of(tb) != 17'd0 && s_r.tdiv[l] >= div_of(tb) - 17'd1; // [RULE_25]
        tr = div_of(rb) != 17'd0 && s_r.rdiv[l] >= div_of(rb) - 17'd1;
        s_nxt.tdiv[l] = tt ? 17'd0 : s_r.tdiv[l] + 17'd1;
        s_nxt.rdiv[l] = tr ? 17'd0 : s_r.rdiv[l] + 17'd1;
      end else begin
        tt = wr && off == `ESM_OFF_CTRL && d[`ESM_C_IOPLS]; // [RULE_25]
        tr = tt;
        s_nxt.tdiv[l] = '0;
        s_nxt.rdiv[l] = '0;
      end
      cts_e = s_r.cfg[l].loop || s_r.md_s[l][0]; // [RULE_15]
      rxin = s_r.cfg[l].loop ? s_r.tx_o[l] : s_r.rx_s[l]; // [RULE_15]
      nb = `ESM_WLEN_BASE + {2'd0, s_r.cfg[l].wlen};
      // Receiver: sample mid-bit, 16 ticks per bit
      if (tr) begin
        if (!s_r.rx_act[l]) begin
          if (!rxin) begin
            s_nxt.rx_act[l] = 1'b1;
            s_nxt.rx_cnt[l] = '0;
            s_nxt.rx_bit[l] = '0;
            s_nxt.rx_par[l] = 1'b0;
          end
        end else begin
          s_nxt.rx_cnt[l] = s_r.rx_cnt[l] + 4'd1;
          if (s_r.rx_cnt[l] == `ESM_OS_MID) begin
            s_nxt.rx_bit[l] = s_r.rx_bit[l] + 4'd1;
            if (s_r.rx_bit[l] == 4'd0) begin
              if (rxin) s_nxt.rx_act[l] = 1'b0;
            end else if (s_r.rx_bit[l] <= nb) begin
              s_nxt.rx_sh[l] = {rxin, s_r.rx_sh[l][7:1]};
              s_nxt.rx_par[l] = s_r.rx_par[l] ^ rxin;
            end else if (s_r.cfg[l].par_en && s_r.rx_bit[l] == nb + 4'd1) begin
              s_nxt.rx_par[l] = s_r.rx_par[l] ^ rxin;
            end else begin
              bad = s_r.cfg[l].par_en && (s_r.rx_par[l] != s_r.cfg[l].par_odd);
              s_nxt.rx_act[l] = 1'b0;
              s_nxt.rx_buf[l] = 8'(s_r.rx_sh[l] >> (4'd8 - nb));
              s_nxt.rx_full[l] = 1'b1; // [RULE_03]
              // A read of this line in the same cycle frees the buffer: no overrun then
              s_nxt.rx_ovr[l] = s_r.rx_full[l] && // [RULE_24]
                                !(rd && off == `ESM_OFF_IN_B && cl == 3'(l));
              s_nxt.rx_ferr[l] = !rxin;
              s_nxt.rx_perr[l] = bad;
            end
          end
        end
      end
      // Transmitter
      if (tt) begin
        if (s_r.tx_left[l] == 4'd0) begin
          if (s_nxt.tx_full[l] && !s_nxt.tx_brk[l] && cts_e) begin
            fr = frame_of(s_nxt.tx_hold[l], s_r.cfg[l]);
            s_nxt.tx_sh[l] = fr[11:0];
            s_nxt.tx_left[l] = fr[15:12];
            s_nxt.tx_full[l] = 1'b0; // [RULE_10]
            s_nxt.tx_cnt[l] = '0;
          end
        end else begin
          s_nxt.tx_cnt[l] = s_r.tx_cnt[l] + 4'd1;
          if (s_r.tx_cnt[l] == `ESM_OS_LAST) begin
            s_nxt.tx_sh[l] = {1'b1, s_r.tx_sh[l][11:1]};
            s_nxt.tx_left[l] = s_r.tx_left[l] - 4'd1;
          end
        end
      end
      s_nxt.tx_o[l] = s_nxt.tx_brk[l] ? 1'b0 :
                      (s_nxt.tx_left[l] != 4'd0 ? s_nxt.tx_sh[l][0] : 1'b1); // [RULE_11]
      if (s_nxt.rts_off[l] && s_nxt.tx_left[l] == 4'd0 && !s_nxt.tx_full[l]) begin
        s_nxt.rts[l] = 1'b0; // [RULE_14]
        s_nxt.rts_off[l] = 1'b0;
      end
      // Modem change detect, only on line
      s_nxt.md_p[l] = s_r.md_s[l];
      if (s_r.online && !s_r.busy && s_r.cfg[l].md_en && s_r.md_s[l] != s_r.md_p[l]) begin
        s_nxt.md_req[l] = 1'b1; // [RULE_12]
      end
      // Service requests in scan order
      req[l] = s_r.rx_full[l] && s_r.cfg[l].rx_en; // [RULE_03]
      req[8 + 2 * l] = s_r.cfg[l].tx_en && !s_r.tx_full[l] && !s_r.tx_brk[l] && cts_e; // [RULE_09]
      req[9 + 2 * l] = s_r.md_req[l] && s_r.cfg[l].md_en;
    end
    // ==========================================================
    // Scanner: restarts from the top after each service, so only the highest is reported.
    // A new higher request waits until the held one is serviced.
    if (!prio) begin // [RULE_21]
      if (s_r.found) begin
        if (!req[s_r.ptr]) begin
          s_nxt.found = 1'b0;
          s_nxt.ptr = '0;
          s_nxt.scan_cnt = '0;
        end
      end else if (req[s_r.ptr]) begin
        s_nxt.found = 1'b1; // [RULE_27]
      end else if (s_r.scan_cnt == 9'(`ESM_SCAN_CYC - 1)) begin
        s_nxt.scan_cnt = '0; // [RULE_22]
        s_nxt.ptr = s_r.ptr == `ESM_LAST_SLOT ? 5'd0 : s_r.ptr + 5'd1;
      end else begin
        s_nxt.scan_cnt = s_r.scan_cnt + 9'd1;
      end
    end
    // ==========================================================
    // Initialisation sequence, one line per cycle
    go_init = (wr && off == `ESM_OFF_CTRL && d[`ESM_C_START]) ||
              (s_r.pin_s[`ESM_SP_BUS_IO_RESET] && !s_r.iord);
    if (go_init) begin
      s_nxt.st = ST_INIT; // [RULE_23]
      s_nxt.init_cnt = '0;
      s_nxt.busy = 1'b1;
      s_nxt.online = 1'b1;
      s_nxt.found = 1'b0;
      s_nxt.ptr = '0;
      s_nxt.scan_cnt = '0;
    end else if (s_r.st == ST_INIT) begin
      s_nxt.cfg[s_r.init_cnt] = '{wlen: `ESM_DEF_WLEN, par_en: `ESM_DEF_PAR_EN, // [RULE_01]
                                  par_odd: `ESM_DEF_PAR_ODD, stop2: `ESM_DEF_STOP2,
                                  baud: s_r.pin_s[`ESM_SP_DEF], default: 1'b0};
      s_nxt.rts[s_r.init_cnt] = 1'b0; // [RULE_01]
      s_nxt.rts_off[s_r.init_cnt] = 1'b0;
      s_nxt.rx_full[s_r.init_cnt] = 1'b0;
      s_nxt.rx_act[s_r.init_cnt] = 1'b0;
      s_nxt.tx_full[s_r.init_cnt] = 1'b0;
      s_nxt.tx_brk[s_r.init_cnt] = 1'b0;
      s_nxt.tx_left[s_r.init_cnt] = '0;
      s_nxt.md_req[s_r.init_cnt] = 1'b0;
      s_nxt.found = 1'b0; // [RULE_23]
      s_nxt.init_cnt = s_r.init_cnt + 3'd1;
      if (s_r.init_cnt == 3'd7) begin
        s_nxt.st = ST_RUN;
        s_nxt.busy = 1'b0; // [RULE_23]
        s_nxt.online = 1'b0; // [RULE_02]
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.busy <= 1'b1;
      s_r.online <= 1'b1;
      s_r.tx_o <= 8'hff;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = {16'h0000, s_r.dat};
  assign irq_o = s_r.found && !prio && !s_r.msk; // [RULE_27]
  assign txd_o = s_r.tx_o;
  assign rts_o = s_r.rts;
  assign dtr_o = s_r.dtr;
  // ==========================================================
  // Assertions
  localparam int SCAN_C = `ESM_SCAN_CYC;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  init_defaults_a: assert property ($fell(s_r.busy) |-> s_r.cfg[7].wlen == 2'd2 && // [RULE_01]
    s_r.cfg[7].stop2 && s_r.cfg[7].par_en && !s_r.cfg[7].par_odd && !s_r.rts[7])
    else $error("line defaults wrong after init");
  init_offline_a: assert property ($fell(s_r.busy) |-> !s_r.online && !s_r.found) // [RULE_23]
    else $error("board not off line after init");
  svc_bit15_a: assert property ($past(rd_a) && s_r.ack |-> // [RULE_04]
    s_r.dat[15] == (s_r.cur_sec == SEC_TX))
    else $error("service read bit 15 wrong");
  stat_bit15_a: assert property ($past(rd_c) && s_r.ack |-> // [RULE_05]
    s_r.dat[15] == ($past(s_r.cur_sec) == SEC_MDM))
    else $error("status read bit 15 wrong");
  brk_space_a: assert property (s_r.tx_brk[0] |-> !s_r.tx_o[0]) // [RULE_11]
    else $error("break not spacing");
  rts_idle_a: assert property ($fell(s_r.rts[0]) && !s_r.busy |-> // [RULE_14]
    s_r.tx_left[0] == 4'd0 && !s_r.tx_full[0])
    else $error("RTS dropped while sending");
  scan_dwell_a: assert property (!s_r.found && !req[s_r.ptr] && !prio && !go_init && // [RULE_22]
    s_r.scan_cnt == 9'(SCAN_C - 1) |=> s_r.ptr == 5'd0 || $past(s_r.ptr) + 5'd1 == s_r.ptr)
    else $error("scanner dwell wrong");
  prio_hold_a: assert property (prio && !go_init |-> !irq_o ##1 // [RULE_21]
    ($stable(s_r.ptr) && $stable(s_r.scan_cnt)))
    else $error("scanner ran during sync priority");
  irq_mask_a: assert property (irq_o |-> !s_r.msk && $past(req[s_r.ptr] || prio)) // [RULE_27]
    else $error("interrupt while masked or without request");
  ack_pulse_a: assert property (s_r.ack |=> !s_r.ack)
    else $error("ack held");
  rx_done_c: cover property (s_r.found && s_r.ptr < 5'd8);
  tx_done_c: cover property (s_r.found && s_r.ptr == 5'd8);
  md_done_c: cover property ($rose(s_r.md_req[0]));
  brk_c: cover property ($rose(s_r.tx_brk[0]));
endmodule

// ---- sim/esm_term.sv ----
// Line-side model: serial terminal and modem for the multiplexer
module esm_term (
  // Bench control
  input wire logic clk_i,
  input wire logic [7:0] dsr_req_i,
  // Line side
  output logic [7:0] rxd_o,
  output logic [7:0] cts_o,
  output logic [7:0] dsr_o,
  output logic [7:0] dcd_o,
  output logic [7:0] ri_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Line levels
  // Receive data rests at mark between characters
  assign rxd_o = 8'hff;
  // Unwired clear-to-send is pulled high, so it reads active
  assign cts_o = 8'hff;
  assign dcd_o = 8'h00;
  assign ri_o = 8'h00;
  // Data set ready lags the bench by a cycle, as a real modem would
  always_ff @(posedge clk_i) begin
    dsr_o <= dsr_req_i;
  end
endmodule

// ---- sim/esm_top_test.sv ----
// Self-checking bench for the eight-line serial multiplexer
module esm_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
    $display("FAIL %0t got %h exp %h", $time, a, e); end end
  logic clk_i, rst_i, req, we, io_rst, prio, wb_ack_o, irq_o;
  logic [31:0] adr, wdat, wb_dat_o;
  logic [7:0] txd_o, rts_o, dtr_o, rxd, cts, dsr, dcd, ri, dsr_req;
  logic [5:0] dev;
  logic [3:0] sel, def_rate;
  logic bdis;
  logic [15:0] q;
  int n_fail, n_compared;
  // ==========================================================
  // Design and line-side model
  esm_top u_esm_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .bus_io_reset_i(io_rst), .sync_prio_i(prio), .irq_o(irq_o),
    .baud_strobe_dis_i(bdis), .devcode_j1_i(1'b1), .devcode_j2_i(1'b0),
    .devcode_j3_i(1'b0), .def_rate_i(def_rate), .ret_rate_i(4'h0), .split_rate_i(8'h00),
    .rxd_i(rxd), .cts_i(cts), .dsr_i(dsr), .dcd_i(dcd), .ri_i(ri), .txd_o(txd_o),
    .rts_o(rts_o), .dtr_o(dtr_o));
  esm_term u_esm_term (.clk_i(clk_i), .dsr_req_i(dsr_req), .rxd_o(rxd), .cts_o(cts),
    .dsr_o(dsr), .dcd_o(dcd), .ri_o(ri));
  // ==========================================================
  // Bus tasks
  task automatic wb(input logic w, input logic [7:0] off, input logic [15:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    req <= 1'b1;
    sel <= 4'h3;
    we <= w;
    adr <= {18'h0, dev, off};
    wdat <= {16'h0, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    q = wb_dat_o[15:0];
    req <= 1'b0;
    `CHK(k < 50, 1'b1)
  endtask
  task automatic rd(input logic [7:0] off, input logic [15:0] e);
    wb(1'b0, off, 16'h0);
    `CHK(q, e)
  endtask
  // Scanner may dwell a full sweep before it reports
  task automatic wait_irq(input logic lvl);
    for (int k = 0; k < 15000 && irq_o !== lvl; k++) @(posedge clk_i);
    `CHK(irq_o, lvl)
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // Clock, watchdog and tests
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    repeat (80000) @(posedge clk_i);
    n_fail++;
    report_and_stop();
  end
  initial begin
    {rst_i, req, we, io_rst, prio, adr, wdat, dsr_req, q, sel, def_rate, bdis} = '0;
    rst_i = 1'b1;
    dev = 6'o34;
    n_fail = 0;
    n_compared = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    io_rst <= 1'b1;
    repeat (4) @(posedge clk_i);
    io_rst <= 1'b0;
    repeat (20) @(posedge clk_i);
    wb(1'b1, 8'h18, 16'h0001);
    rd(8'h18, 16'h000a);
    repeat (12) @(posedge clk_i);
    rd(8'h18, 16'h0000);
    `CHK(rts_o, 8'h00)
    dev = 6'o44;
    wb(1'b1, 8'h18, 16'h0001);
    dev = 6'o34;
    rd(8'h18, 16'h0000);
    wb(1'b1, 8'h00, 16'h0000);
    wb(1'b1, 8'h08, 16'h000b);
    wb(1'b1, 8'h04, 16'h0055);
    repeat (200) wb(1'b1, 8'h18, 16'h0004);
    // Drop the transmitter so the receiver is the only requester
    wb(1'b1, 8'h08, 16'h0009);
    wait_irq(1'b1);
    rd(8'h0c, 16'h0000);
    rd(8'h14, 16'h0000);
    wb(1'b0, 8'h10, 16'h0000);
    `CHK(q[7:0], 8'h55)
    wb(1'b1, 8'h08, 16'h000b);
    wait_irq(1'b1);
    rd(8'h0c, 16'h8000);
    wb(1'b1, 8'h08, 16'h0005);
    wb(1'b1, 8'h18, 16'h0002);
    wait_irq(1'b1);
    rd(8'h0c, 16'h0000);
    rd(8'h14, 16'h8800);
    rd(8'h18, 16'h0006);
    prio <= 1'b1;
    repeat (4) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    prio <= 1'b0;
    wb(1'b1, 8'h18, 16'h0002);
    wait_irq(1'b0);
    dsr_req <= 8'h01;
    wait_irq(1'b1);
    rd(8'h0c, 16'h0000);
    rd(8'h14, 16'h9800);
    wb(1'b1, 8'h18, 16'h0008);
    wait_irq(1'b0);
    wb(1'b1, 8'h04, 16'h8200);
    repeat (2) @(posedge clk_i);
    `CHK({dtr_o[0], rts_o[0]}, 2'b10)
    wb(1'b1, 8'h04, 16'h4200);
    repeat (2) @(posedge clk_i);
    `CHK({dtr_o[0], rts_o[0]}, 2'b01)
    wb(1'b1, 8'h04, 16'h0100);
    repeat (4) @(posedge clk_i);
    `CHK(txd_o[0], 1'b0)
    report_and_stop();
  end
endmodule
